// ### rtl/lsd_pkg.sv
// Constants for the segment LCD driver control block.
// Assumes an 8-bit special-function register port on a 40 MHz clock.
package lsd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [7:0] ADDR_DISPLAY_CONFIG = 8'h95;
  localparam logic [7:0] ADDR_DISPLAY_CLOCK_CTRL = 8'h96;
  localparam logic [7:0] ADDR_SEGMENT_ENABLE_HI = 8'h97;
  localparam logic [7:0] ADDR_DISPLAY_MEM_POINTER = 8'hac;
  localparam logic [7:0] ADDR_DISPLAY_MEM_DATA = 8'hae;
  localparam logic [7:0] ADDR_SCREEN_SCROLL_CONFIG = 8'hb1;
  localparam logic [7:0] ADDR_SEGMENT_ENABLE_LO = 8'hed;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_MEM_CLEAR_BIT = 6;
  localparam int CFG_BLINK_ON_BIT = 5;
  localparam int CFG_TIMEBASE_BIT = 3;
  localparam int CFG_MUX_LSB = 0;
  localparam int CLK_STYLE_LSB = 6;
  localparam int CLK_RATE_LSB = 4;
  localparam int CLK_DIVIDER_LSB = 0;
  localparam int PTR_WRITE_BIT = 7;
  localparam int PTR_PAGE_LSB = 4;
  localparam int PTR_ADDR_LSB = 0;
  localparam int SCROLL_AUTO_BIT = 7;
  localparam int SCROLL_PAGE_LSB = 2;
  localparam int SCROLL_FREEZE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SEG_HI_MASK = 8'hfc;
  localparam logic [7:0] SEG_LO_MASK = 8'h0f;
  localparam logic [7:0] PTR_MASK = 8'hbf;
  localparam logic [7:0] CFG_MASK = 8'hbf;
  localparam logic [28:0] SEG_PIN_RESET = 29'h1800ffff;

  ////////////////////////////////////////////////////////////////////////////
  // Memory geometry
  localparam int MEM_BYTES = 15;
  localparam int MEM_PAGES = 4;
  localparam int SEG_LINES = 29;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: the prescaler ticks at twice the selected timebase
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEBASE_FAST_HZ = 2048;
  localparam int TIMEBASE_SLOW_HZ = 128;
  localparam int FAST_TICK_CYCLES = CLK_HZ / (2 * TIMEBASE_FAST_HZ);
  localparam int SLOW_TICK_CYCLES = CLK_HZ / (2 * TIMEBASE_SLOW_HZ);
  // Blink half periods in fast timebase ticks; slow base divides by 16
  localparam logic [12:0] BLINK_RATE0_TICKS = 13'h0800;
  localparam logic [12:0] BLINK_RATE1_TICKS = 13'h0400;
  localparam logic [12:0] BLINK_RATE2_TICKS = 13'h0200;
  localparam logic [12:0] BLINK_RATE3_TICKS = 13'h0100;
  localparam logic [12:0] BLINK_SLOW_TICKS = 13'h1000;
  localparam int SLOW_BASE_SHIFT = 4;

  typedef enum logic [1:0] {
    MUX_STATIC = 2'b00,
    MUX_TWO = 2'b01,
    MUX_THREE = 2'b10,
    MUX_FOUR = 2'b11
  } lsd_mux_e;

  typedef enum logic [1:0] {
    STYLE_BLANK = 2'b00,
    STYLE_SHOW = 2'b01,
    STYLE_AUTO_SLOW = 2'b10,
    STYLE_AUTO = 2'b11
  } lsd_style_e;

endpackage : lsd_pkg

// ### rtl/lsd_ctrl.sv
// Segment LCD driver control: registers, display memory, timing, blink, scroll.
// Assumes the register port is synchronous to clk and one access per cycle.
//
// Contract
// - Mux 10 makes pin 28 common two; 11 adds 27.
// - Shared pins 27, 28 are segments after reset.
// - Lines 0-15 always on; 16-25 need enables.
// - Shared pin enables independent; disabled keeps GPIO.
// - Memory-clear bit zeroes all display memory.
// - Reset clears all display memory.
// - Timebase bit picks 2048 Hz or 128 Hz.
// - Frame and step rates from timebase, mux, divider.
// - Waveform frequency is common-advance rate.
// - Divider ranges 8-128 Hz fast, 8-32 slow.
// - Polarity inverts at twice common-step rate.
// - Blink enable alternates shown and blanked display.
// - Software blink shows or blanks per style.
// - Automatic blink at one of five rates.
// - Four screens; unfrozen shows selected screen.
// - Auto scroll plus blink steps screens at rate.
// - Scrolling keeps running in every power mode.
// - Four banks of fifteen bytes, two page bits.
// - Byte drives two lines, low nibble even.
// - Display memory kept through deep sleep.
// - Pointer write selects byte, launches transfer.
// - Pointer bit 7 writes, else reads into data.
// - Pointer: write bit 7, page 5:4, address 3:0.
// - Freeze keeps previous image while memory updates.
module lsd_ctrl
  import lsd_pkg::*;
#(
  parameter int FAST_DIV = FAST_TICK_CYCLES,
  parameter int SLOW_DIV = SLOW_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  output logic [7:0] sfrRdData,
  output logic [3:0] commonActive,
  output logic drivePolarity,
  output logic [SEG_LINES-1:0] segmentData,
  output logic [SEG_LINES-1:0] segmentPinLcd,
  output logic pin27IsCommon,
  output logic pin28IsCommon
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] cfgReg;
  logic [7:0] clkCtrlReg;
  logic [7:0] segHiReg;
  logic [7:0] segLoReg;
  logic [7:0] ptrReg;
  logic [7:0] dataReg;
  logic [7:0] scrollReg;
  logic [7:0] memReg [MEM_PAGES][MEM_BYTES];
  logic [7:0] imageReg [MEM_BYTES];

  logic cfgWr, ptrWr, memClear;
  logic [1:0] ptrPage;
  logic [3:0] ptrAddr;
  lsd_mux_e muxSel;
  lsd_style_e blinkStyle;
  logic blinkOn, slowBase, freeze, scrollOn, autoBlink;

  assign cfgWr = sfrWrEn && (sfrAddr == ADDR_DISPLAY_CONFIG);
  assign ptrWr = sfrWrEn && (sfrAddr == ADDR_DISPLAY_MEM_POINTER);
  assign memClear = cfgWr && sfrWrData[CFG_MEM_CLEAR_BIT];
  assign ptrPage = sfrWrData[PTR_PAGE_LSB +: 2];
  assign ptrAddr = sfrWrData[PTR_ADDR_LSB +: 4];
  assign muxSel = lsd_mux_e'(cfgReg[CFG_MUX_LSB +: 2]);
  assign blinkStyle = lsd_style_e'(clkCtrlReg[CLK_STYLE_LSB +: 2]);
  assign blinkOn = cfgReg[CFG_BLINK_ON_BIT];
  assign slowBase = cfgReg[CFG_TIMEBASE_BIT];
  assign freeze = scrollReg[SCROLL_FREEZE_BIT];
  assign scrollOn = scrollReg[SCROLL_AUTO_BIT] && blinkOn;
  assign autoBlink = blinkOn && blinkStyle[1];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfgReg <= REG_RESET;
      clkCtrlReg <= REG_RESET;
      segHiReg <= REG_RESET;
      segLoReg <= REG_RESET;
      scrollReg <= REG_RESET;
      ptrReg <= REG_RESET;
    end else if (sfrWrEn) begin
      unique case (sfrAddr)
        ADDR_DISPLAY_CONFIG: cfgReg <= sfrWrData & CFG_MASK;
        ADDR_DISPLAY_CLOCK_CTRL: clkCtrlReg <= sfrWrData;
        ADDR_SEGMENT_ENABLE_HI: segHiReg <= sfrWrData & SEG_HI_MASK;
        ADDR_SEGMENT_ENABLE_LO: segLoReg <= sfrWrData & SEG_LO_MASK;
        ADDR_SCREEN_SCROLL_CONFIG: scrollReg <= sfrWrData;
        ADDR_DISPLAY_MEM_POINTER: ptrReg <= sfrWrData & PTR_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display memory and indirect access
  always_ff @(posedge clk) begin
    if (!reset_n || memClear) begin
      for (int p = 0; p < MEM_PAGES; p++) begin
        for (int b = 0; b < MEM_BYTES; b++) begin
          memReg[p][b] <= 8'h00;
        end
      end
    end else if (ptrWr && sfrWrData[PTR_WRITE_BIT] && ptrAddr < 4'(MEM_BYTES)) begin
      memReg[ptrPage][ptrAddr] <= dataReg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dataReg <= REG_RESET;
    end else if (sfrWrEn && sfrAddr == ADDR_DISPLAY_MEM_DATA) begin
      dataReg <= sfrWrData;
    end else if (ptrWr && !sfrWrData[PTR_WRITE_BIT]) begin
      dataReg <= (ptrAddr < 4'(MEM_BYTES)) ? memReg[ptrPage][ptrAddr] : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sfrRdData <= 8'h00;
    end else begin
      unique case (sfrAddr)
        ADDR_DISPLAY_CONFIG: sfrRdData <= cfgReg;
        ADDR_DISPLAY_CLOCK_CTRL: sfrRdData <= clkCtrlReg;
        ADDR_SEGMENT_ENABLE_HI: sfrRdData <= segHiReg;
        ADDR_SEGMENT_ENABLE_LO: sfrRdData <= segLoReg;
        ADDR_SCREEN_SCROLL_CONFIG: sfrRdData <= scrollReg;
        ADDR_DISPLAY_MEM_POINTER: sfrRdData <= ptrReg;
        ADDR_DISPLAY_MEM_DATA: sfrRdData <= dataReg;
        default: sfrRdData <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase prescaler, ticks at twice the selected timebase
  logic [17:0] preCntReg;
  logic [17:0] preLimit;
  logic tick, baseTick, tickPhaseReg;

  assign preLimit = slowBase ? 18'(SLOW_DIV - 1) : 18'(FAST_DIV - 1);
  assign tick = (preCntReg >= preLimit);
  assign baseTick = tick && tickPhaseReg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      preCntReg <= '0;
      tickPhaseReg <= 1'b0;
    end else if (tick) begin
      preCntReg <= '0;
      tickPhaseReg <= !tickPhaseReg;
    end else begin
      preCntReg <= preCntReg + 18'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common stepping and polarity inversion
  // Seven bits: divider 15 needs 64 ticks
  function automatic logic [6:0] halfTicks(input logic slow, input logic [3:0] fd);
    if (slow) begin
      halfTicks = (fd[1:0] == 2'b11) ? 7'd4 : 7'(1 << fd[1:0]);
    end else begin
      halfTicks = {1'b0, fd, 2'b00} + 7'd4;
    end
  endfunction : halfTicks

  logic [6:0] halfCntReg;
  logic halfPhaseReg;
  logic [1:0] comReg;
  logic halfDone;

  assign halfDone = tick && (halfCntReg + 7'd1 >= halfTicks(slowBase,
      clkCtrlReg[CLK_DIVIDER_LSB +: 4]));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      halfCntReg <= '0;
      halfPhaseReg <= 1'b0;
      comReg <= 2'd0;
    end else if (halfDone) begin
      halfCntReg <= '0;
      halfPhaseReg <= !halfPhaseReg;
      if (halfPhaseReg) begin
        comReg <= (comReg >= muxSel) ? 2'd0 : comReg + 2'd1;
      end
    end else if (tick) begin
      halfCntReg <= halfCntReg + 7'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink and scroll timing
  function automatic logic [12:0] blinkTicks(input lsd_style_e st, input logic [1:0] rate,
                                             input logic slow);
    logic [12:0] t;
    t = BLINK_SLOW_TICKS;
    if (st == STYLE_AUTO) begin
      unique case (rate)
        2'd0: t = BLINK_RATE0_TICKS;
        2'd1: t = BLINK_RATE1_TICKS;
        2'd2: t = BLINK_RATE2_TICKS;
        2'd3: t = BLINK_RATE3_TICKS;
      endcase
    end
    blinkTicks = slow ? (t >> SLOW_BASE_SHIFT) : t;
  endfunction : blinkTicks

  logic [12:0] blinkCntReg;
  logic blinkEvent, visibleReg, blinkPhaseReg;
  logic [1:0] scrollPageReg;

  assign blinkEvent = baseTick && (blinkCntReg + 13'd1 >= blinkTicks(blinkStyle,
      clkCtrlReg[CLK_RATE_LSB +: 2], slowBase));

  always_ff @(posedge clk) begin
    if (!reset_n || !(autoBlink || scrollOn)) begin
      blinkCntReg <= '0;
      blinkPhaseReg <= 1'b1;
    end else if (blinkEvent) begin
      blinkCntReg <= '0;
      blinkPhaseReg <= !blinkPhaseReg;
    end else if (baseTick) begin
      blinkCntReg <= blinkCntReg + 13'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scrollPageReg <= 2'd0;
    end else if (scrollOn && blinkEvent) begin
      scrollPageReg <= scrollPageReg + 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !blinkOn || scrollOn) begin
      visibleReg <= 1'b1;
    end else if (autoBlink) begin
      visibleReg <= blinkPhaseReg;
    end else begin
      visibleReg <= blinkStyle[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Image latch, frozen while firmware updates memory
  logic [1:0] livePage;
  logic [1:0] shownPageReg;

  assign livePage = scrollOn ? scrollPageReg : scrollReg[SCROLL_PAGE_LSB +: 2];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shownPageReg <= 2'd0;
      for (int b = 0; b < MEM_BYTES; b++) begin
        imageReg[b] <= 8'h00;
      end
    end else if (!freeze) begin
      shownPageReg <= livePage;
      for (int b = 0; b < MEM_BYTES; b++) begin
        imageReg[b] <= memReg[livePage][b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      segmentPinLcd <= SEG_PIN_RESET;
      pin27IsCommon <= 1'b0;
      pin28IsCommon <= 1'b0;
      commonActive <= 4'h0;
      drivePolarity <= 1'b0;
      segmentData <= '0;
    end else begin
      segmentPinLcd[15:0] <= 16'hffff;
      segmentPinLcd[19:16] <= segLoReg[3:0];
      segmentPinLcd[25:20] <= segHiReg[7:2];
      segmentPinLcd[26] <= 1'b0;
      segmentPinLcd[27] <= (muxSel != MUX_FOUR);
      segmentPinLcd[28] <= !muxSel[1];
      pin27IsCommon <= (muxSel == MUX_FOUR);
      pin28IsCommon <= muxSel[1];
      commonActive <= 4'(1 << comReg);
      drivePolarity <= halfPhaseReg;
      for (int s = 0; s < SEG_LINES; s++) begin
        segmentData[s] <= (visibleReg && imageReg[s / 2][(s % 2) * 4 + comReg])
            ^ halfPhaseReg;
      end
      if (muxSel[1]) begin
        segmentData[28] <= 1'b0;
      end
      if (muxSel == MUX_FOUR) begin
        segmentData[27] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic memAllZero;
  always_comb begin
    memAllZero = 1'b1;
    for (int p = 0; p < MEM_PAGES; p++) begin
      for (int b = 0; b < MEM_BYTES; b++) begin
        memAllZero = memAllZero && (memReg[p][b] == 8'h00);
      end
    end
  end

  mem_clear_a: assert property (memClear |=> memAllZero)
    else $error("display memory not cleared");
  ptr_read_a: assert property (ptrWr && ptrAddr < 4'd15 && !sfrWrData[7]
      |=> dataReg == memReg[ptrReg[5:4]][ptrReg[3:0]])
    else $error("pointer read did not load data register");
  ptr_write_a: assert property (ptrWr && ptrAddr < 4'd15 && sfrWrData[7]
      |=> memReg[ptrReg[5:4]][ptrReg[3:0]] == $past(dataReg))
    else $error("pointer write did not store data");
  pin_common_a: assert property (##1 pin28IsCommon == $past(cfgReg[1])
      && segmentPinLcd[27] == !($past(cfgReg[1:0]) == 2'b11))
    else $error("shared pin role wrong");
  fixed_segs_a: assert property (segmentPinLcd[15:0] == 16'hffff)
    else $error("fixed segment lines not enabled");
  // First common after reset comes without an inversion
  invert_step_a: assert property ($changed(commonActive) && $past(commonActive) != 4'h0
      |-> $changed(drivePolarity))
    else $error("common advanced without inversion");
  soft_blank_a: assert property (blinkOn && !scrollOn && blinkStyle == STYLE_BLANK
      |=> !visibleReg)
    else $error("software blank not applied");
  screen_sel_a: assert property (!freeze && !scrollOn
      |=> shownPageReg == $past(scrollReg[3:2]))
    else $error("selected screen not shown");
  freeze_hold_a: assert property (freeze |=> $stable(shownPageReg))
    else $error("image changed while frozen");
  scroll_step_a: assert property (scrollOn && blinkEvent
      |=> scrollPageReg == $past(scrollPageReg) + 2'd1)
    else $error("scroll did not advance");

endmodule : lsd_ctrl

// ### testbench/lsd_glass_model.sv
// Passive segment glass: remembers which pixel each common/segment pair shows.
// Assumes segment and common outputs are registered together by the driver.
module lsd_glass_model
  import lsd_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] commonActive,
  input wire logic drivePolarity,
  input wire logic [SEG_LINES-1:0] segmentData,
  input wire logic [SEG_LINES-1:0] segmentPinLcd,
  output logic [SEG_LINES-1:0][3:0] litMap
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] prevCommon;

  always_ff @(posedge clk) begin
    prevCommon <= commonActive;
  end

  // Sample only once the common is settled
  always_ff @(posedge clk) begin
    if (commonActive == prevCommon) begin
      for (int l = 0; l < SEG_LINES; l++) begin
        for (int n = 0; n < 4; n++) begin
          if (commonActive[n]) begin
            litMap[l][n] <= segmentPinLcd[l] & (segmentData[l] ^ drivePolarity);
          end
        end
      end
    end
  end
endmodule : lsd_glass_model

// ### testbench/tb_top.sv
// Self-checking bench for the segment LCD driver control block.
// Assumes shortened prescaler divisors and the glass model on the display side.
`define CHECK(what, expv, gotv) begin samplesChecked++; if ((gotv) !== (expv)) begin \
  errCount++; $display("wrong value %s expected %0h seen %0h", what, expv, gotv); end end

module tb_top
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrRdData;
  logic [3:0] commonActive;
  logic drivePolarity;
  logic [SEG_LINES-1:0] segmentData;
  logic [SEG_LINES-1:0] segmentPinLcd;
  logic pin27IsCommon;
  logic pin28IsCommon;
  logic [SEG_LINES-1:0][3:0] litMap;
  int errCount = 0;
  int samplesChecked = 0;

  always #12.5 clk = ~clk;

  lsd_ctrl #(.FAST_DIV(4), .SLOW_DIV(8)) dut (.clk(clk), .reset_n(reset_n),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdData(sfrRdData),
    .commonActive(commonActive), .drivePolarity(drivePolarity), .segmentData(segmentData),
    .segmentPinLcd(segmentPinLcd), .pin27IsCommon(pin27IsCommon),
    .pin28IsCommon(pin28IsCommon));

  lsd_glass_model glass (.clk(clk), .commonActive(commonActive),
    .drivePolarity(drivePolarity), .segmentData(segmentData),
    .segmentPinLcd(segmentPinLcd), .litMap(litMap));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clk);
    sfrWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    @(posedge clk);
    @(posedge clk);
    #1;
    d = sfrRdData;
  endtask : rd

  task automatic memWr(input logic [1:0] p, input logic [3:0] a, input logic [7:0] d);
    wr(ADDR_DISPLAY_MEM_DATA, d);
    wr(ADDR_DISPLAY_MEM_POINTER, {2'b11, p, a});
  endtask : memWr

  task automatic memRd(input logic [1:0] p, input logic [3:0] a, output logic [7:0] d);
    wr(ADDR_DISPLAY_MEM_POINTER, {2'b00, p, a});
    rd(ADDR_DISPLAY_MEM_DATA, d);
  endtask : memRd

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] addrs [8];
    logic [7:0] v;
    addrs = '{8'h95, 8'h96, 8'h97, 8'hac, 8'hae, 8'hb1, 8'hed, 8'h90};
    `CHECK("pin roles", 29'h1800ffff, segmentPinLcd)
    `CHECK("pin27 common", 1'b0, pin27IsCommon)
    `CHECK("pin28 common", 1'b0, pin28IsCommon)
    foreach (addrs[i]) begin
      rd(addrs[i], v);
      `CHECK("reset reg", 8'h00, v)
    end
    memRd(2'd3, 4'd14, v);
    `CHECK("reset mem", 8'h00, v)
  endtask : t_reset

  task automatic t_roles();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_DISPLAY_CONFIG, 8'(m));
      pause(2);
      #1;
      `CHECK("pin28 common", 1'(m >= 2), pin28IsCommon)
      `CHECK("pin27 common", 1'(m == 3), pin27IsCommon)
    end
  endtask : t_roles

  task automatic t_enables();
    logic [7:0] v;
    wr(ADDR_SEGMENT_ENABLE_HI, 8'h24);
    wr(ADDR_SEGMENT_ENABLE_LO, 8'h05);
    pause(2);
    #1;
    `CHECK("subset roles", 27'h095ffff, segmentPinLcd[26:0])
    wr(ADDR_SEGMENT_ENABLE_HI, 8'hff);
    wr(ADDR_SEGMENT_ENABLE_LO, 8'hff);
    pause(2);
    #1;
    `CHECK("all roles", 27'h3ffffff, segmentPinLcd[26:0])
    rd(ADDR_SEGMENT_ENABLE_HI, v);
    `CHECK("seg hi", 8'hfc, v)
    rd(ADDR_SEGMENT_ENABLE_LO, v);
    `CHECK("seg lo", 8'h0f, v)
  endtask : t_enables

  task automatic t_mem();
    logic [7:0] v;
    for (int p = 0; p < 4; p++) begin
      memWr(2'(p), 4'd0, 8'h11 * 8'(p + 1));
      memWr(2'(p), 4'd14, 8'h80 | 8'(p));
    end
    rd(ADDR_DISPLAY_MEM_POINTER, v);
    `CHECK("pointer", 8'hbe, v)
    for (int p = 3; p >= 0; p--) begin
      memRd(2'(p), 4'd0, v);
      `CHECK("mem byte0", 8'h11 * 8'(p + 1), v)
      memRd(2'(p), 4'd14, v);
      `CHECK("mem byte14", 8'h80 | 8'(p), v)
    end
    wr(ADDR_DISPLAY_CONFIG, 8'h43);
    rd(ADDR_DISPLAY_CONFIG, v);
    `CHECK("config", 8'h03, v)
    memRd(2'd2, 4'd14, v);
    `CHECK("cleared", 8'h00, v)
  endtask : t_mem

  task automatic measure(output int cyc, output int pols);
    logic [3:0] c0;
    logic p;
    int n;
    n = 0;
    c0 = commonActive;
    while (commonActive === c0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    c0 = commonActive;
    p = drivePolarity;
    cyc = 0;
    pols = 0;
    while (commonActive === c0 && cyc < 2000) begin
      @(posedge clk);
      #1;
      cyc++;
      if (drivePolarity !== p) pols++;
      p = drivePolarity;
    end
    `CHECK("next common", (c0 == 4'h8) ? 4'h1 : (c0 << 1), commonActive)
  endtask : measure

  task automatic t_rates();
    logic [7:0] cfg [4] = '{8'h03, 8'h03, 8'h0b, 8'h0b};
    logic [7:0] clkv [4] = '{8'h40, 8'h4f, 8'h40, 8'h43};
    int steps [4] = '{32, 512, 16, 64};
    int cyc;
    int pols;
    foreach (cfg[i]) begin
      wr(ADDR_DISPLAY_CONFIG, cfg[i]);
      wr(ADDR_DISPLAY_CLOCK_CTRL, clkv[i]);
      measure(cyc, pols);
      measure(cyc, pols);
      `CHECK("step cycles", steps[i], cyc)
      `CHECK("inversions", 2, pols)
    end
  endtask : t_rates

  task automatic t_image();
    logic seen;
    logic seenOff;
    logic [3:0] first;
    wr(ADDR_DISPLAY_CONFIG, 8'h03);
    wr(ADDR_DISPLAY_CLOCK_CTRL, 8'h40);
    memWr(2'd0, 4'd0, 8'h21);
    memWr(2'd0, 4'd7, 8'h84);
    pause(1200);
    `CHECK("line0", 4'h1, litMap[0])
    `CHECK("line1", 4'h2, litMap[1])
    `CHECK("line15", 4'h8, litMap[15])
    wr(ADDR_SCREEN_SCROLL_CONFIG, 8'h01);
    memWr(2'd0, 4'd0, 8'hff);
    pause(1200);
    `CHECK("frozen", 4'h1, litMap[0])
    wr(ADDR_SCREEN_SCROLL_CONFIG, 8'h00);
    pause(1200);
    `CHECK("unfrozen", 4'hf, litMap[0])
    memWr(2'd1, 4'd0, 8'h5a);
    wr(ADDR_SCREEN_SCROLL_CONFIG, 8'h04);
    pause(1200);
    `CHECK("screen1", 4'ha, litMap[0])
    wr(ADDR_DISPLAY_CLOCK_CTRL, 8'h00);
    wr(ADDR_DISPLAY_CONFIG, 8'h23);
    pause(1200);
    `CHECK("blanked", 4'h0, litMap[0])
    wr(ADDR_DISPLAY_CLOCK_CTRL, 8'h40);
    pause(1200);
    `CHECK("shown", 4'ha, litMap[0])
    // Style 11 with fastest rate steps screens every half period
    wr(ADDR_DISPLAY_CLOCK_CTRL, 8'hf0);
    wr(ADDR_SCREEN_SCROLL_CONFIG, 8'h80);
    pause(600);
    first = litMap[0];
    seen = 1'b0;
    repeat (10) begin
      pause(600);
      if (litMap[0] !== first) seen = 1'b1;
    end
    `CHECK("scrolled", 1'b1, seen)
    // Slowest automatic rate on the slow base; page 0 byte 0 is all on
    wr(ADDR_SCREEN_SCROLL_CONFIG, 8'h00);
    wr(ADDR_DISPLAY_CLOCK_CTRL, 8'hb0);
    wr(ADDR_DISPLAY_CONFIG, 8'h2b);
    seen = 1'b0;
    seenOff = 1'b0;
    repeat (10) begin
      pause(1000);
      if (litMap[0] === 4'hf) seen = 1'b1;
      if (litMap[0] === 4'h0) seenOff = 1'b1;
    end
    `CHECK("auto blink", 2'b11, {seen, seenOff})
  endtask : t_image

  ////////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : reportAndStop

  initial begin
    repeat (60000) @(posedge clk);
    errCount++;
    reportAndStop();
  end

  initial begin
    pause(16);
    reset_n <= 1'b1;
    pause(2);
    #1;
    t_reset();
    t_roles();
    t_enables();
    t_mem();
    t_rates();
    t_image();
    reportAndStop();
  end
endmodule : tb_top
